// ---- design/pvc_arbiter.sv ----
// picks the highest priority eligible source, lower index on a tie
`timescale 1ns/1ps
module pvc_arbiter
(
  // candidates
  input wire logic [pvc_pkg::NSRC-1:0] eligible,
  input wire logic [pvc_pkg::NSRC*pvc_pkg::PRI_SLOT-1:0] pri_flat,
  // winner
  output pvc_pkg::pvc_win_t win
);

  always_comb
  begin
    logic [pvc_pkg::PRI_W-1:0] p;
    p = pvc_pkg::PRI_NONE;
    win = '0;
    // downward scan with >= lets the lower index win ties
    for (int i = pvc_pkg::NSRC - 1; i >= 0; i--)
    begin
      p = pvc_pkg::pri_of(pri_flat, i);
      if (eligible[i] && (p != pvc_pkg::PRI_NONE) && (p >= win.pri))
      begin
        win.valid = 1'b1;
        win.idx = i[pvc_pkg::IDX_W-1:0];
        win.pri = p;
      end
    end
  end

endmodule

// ---- design/pvc_controller.sv ----
// prioritized vectored interrupt controller top
`timescale 1ns/1ps

// Contract
// - each source has a flag set by its request, held until software clears it
// - each source has its own enable; only enabled sources can interrupt
// - each source has a priority field selecting one of eight levels
// - a selected interrupt latches its 8-bit vector and 4-bit new level
// - the latched new level equals the winning source priority
// - flag, enable and priority positions follow ascending vector order
// - external request zero is vector 8, bit 0, priority bits 2:0
// - three low cpu level bits are software writable
// - the fourth cpu level bit is read-only, so traps stay unmaskable
// - control one holds nesting disable and trap control and status flags
// - control two holds global enable, edge polarity, alternate table select
// - control four holds software hard trap and double-bit error flag
module pvc_controller
(
  // clock, reset and freeze
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  // request sources
  input wire logic [pvc_pkg::NEXT-1:0] ext_irq_in,
  input wire logic [pvc_pkg::NSRC-1:pvc_pkg::NEXT] periph_req,
  // flag, enable and priority registers
  input wire logic [pvc_pkg::NSRC-1:0] irq_flag_clr,
  input wire logic [pvc_pkg::NSRC-1:0] irq_enable_regs,
  input wire logic [pvc_pkg::NSRC*pvc_pkg::PRI_SLOT-1:0] irq_priority_regs,
  // control one
  input wire logic nesting_disable,
  input wire logic [pvc_pkg::NTRAP-1:0] trap_event,
  input wire logic [pvc_pkg::NTRAP-1:0] trap_event_en,
  input wire logic [pvc_pkg::NTRAP-1:0] trap_flag_clr,
  // control two
  input wire logic global_irq_enable,
  input wire logic [pvc_pkg::NEXT-1:0] ext_edge_falling,
  input wire logic alternate_vector_table,
  // control four
  input wire logic soft_hard_trap,
  input wire logic ecc_dbe_event,
  input wire logic double_bit_error_clr,
  // cpu side
  input wire logic cpu_level_wr,
  input wire logic [pvc_pkg::PRI_W-1:0] cpu_level_wdata,
  input wire logic irq_ack,
  input wire logic trap_ack,
  input wire logic trap_return,
  // status outputs
  output logic [pvc_pkg::NSRC-1:0] irq_flag_regs_q,
  output logic [pvc_pkg::NTRAP-1:0] trap_status_q,
  output logic double_bit_error_trap_q,
  output logic [pvc_pkg::LVL_W-1:0] cpu_priority_level_q,
  output logic [pvc_pkg::VEC_W-1:0] vector_number_q,
  output logic [pvc_pkg::LVL_W-1:0] new_cpu_level_q,
  output logic irq_req_q,
  output logic trap_req_q,
  output logic alt_table_sel_q
);

  // ****************************************************************
  // declarations
  // ****************************************************************
  pvc_pkg::pvc_state_t st_q;
  pvc_pkg::pvc_state_t st_d;
  pvc_pkg::pvc_win_t win;
  logic [pvc_pkg::NEXT-1:0] ext_pulse;
  logic [pvc_pkg::NSRC-1:0] set_vec;
  logic [pvc_pkg::NSRC-1:0] eligible;
  logic [pvc_pkg::LVL_W-1:0] cur_lvl;
  logic take;
  logic any_ranked;
  logic outranked;
  logic tie_lost;

  // ****************************************************************
  // sources
  // ****************************************************************
  pvc_edge_detect u_edge
  (
    .clk(clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .ext_in(ext_irq_in),
    .edge_falling(ext_edge_falling),
    .edge_pulse(ext_pulse)
  );

  // external request zero lands on bit 0, peripherals follow upward
  assign set_vec = {periph_req, ext_pulse};
  assign eligible = st_q.flag & irq_enable_regs & {pvc_pkg::NSRC{global_irq_enable}};
  assign cur_lvl = {st_q.lvl_msb, st_q.cpu_lvl};

  // ****************************************************************
  // arbitration
  // ****************************************************************
  pvc_arbiter u_arb
  (
    .eligible(eligible),
    .pri_flat(irq_priority_regs),
    .win(win)
  );

  // a set level msb lifts the cpu above every user priority
  assign take = win.valid && pvc_pkg::above_level(win.pri, cur_lvl);

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb
  begin
    st_d = st_q;
    if (ce)
    begin
      // set wins over a clear in the same cycle
      st_d.flag = (st_q.flag & ~irq_flag_clr) | set_vec;
      st_d.trap_flag = (st_q.trap_flag & ~trap_flag_clr) | (trap_event & trap_event_en);
      st_d.dbe_flag = (st_q.dbe_flag & ~double_bit_error_clr) | ecc_dbe_event;
      st_d.trap_req = (|st_q.trap_flag) | st_q.dbe_flag | soft_hard_trap;
      st_d.alt_tbl = alternate_vector_table;
      st_d.irq_req = take;
      if (take)
      begin
        st_d.vec = pvc_pkg::vector_of(win.idx);
        st_d.new_lvl = {1'b0, win.pri};
      end
      // acknowledge beats a software write of the level
      if (irq_ack)
      begin
        st_d.cpu_lvl = nesting_disable ? pvc_pkg::CPU_LVL_MAX : st_q.new_lvl[pvc_pkg::PRI_W-1:0];
      end
      else if (cpu_level_wr)
      begin
        st_d.cpu_lvl = cpu_level_wdata;
      end
      // only trap entry and exit move the msb; software has no path
      if (trap_ack)
      begin
        st_d.lvl_msb = 1'b1;
      end
      else if (trap_return)
      begin
        st_d.lvl_msb = 1'b0;
      end
    end
  end

  // ****************************************************************
  // state
  // ****************************************************************
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      st_q <= '0;
      st_q.cpu_lvl <= pvc_pkg::CPU_LVL_RST;
      st_q.vec <= pvc_pkg::VEC_RST;
      st_q.new_lvl <= pvc_pkg::LVL_RST;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign irq_flag_regs_q = st_q.flag;
  assign trap_status_q = st_q.trap_flag;
  assign double_bit_error_trap_q = st_q.dbe_flag;
  assign cpu_priority_level_q = cur_lvl;
  assign vector_number_q = st_q.vec;
  assign new_cpu_level_q = st_q.new_lvl;
  assign irq_req_q = st_q.irq_req;
  assign trap_req_q = st_q.trap_req;
  assign alt_table_sel_q = st_q.alt_tbl;

  // ****************************************************************
  // assertion helpers
  // ****************************************************************
  // upward scan, kept apart from the arbiter so a shared slip cannot hide
  always_comb
  begin
    logic [pvc_pkg::PRI_W-1:0] cp;
    cp = pvc_pkg::PRI_NONE;
    any_ranked = 1'b0;
    outranked = 1'b0;
    tie_lost = 1'b0;
    for (int i = 0; i < pvc_pkg::NSRC; i++)
    begin
      cp = pvc_pkg::pri_of(irq_priority_regs, i);
      if (eligible[i] && (cp != pvc_pkg::PRI_NONE))
      begin
        any_ranked = 1'b1;
        if (cp > win.pri)
        begin
          outranked = 1'b1;
        end
        if ((cp == win.pri) && (i[pvc_pkg::IDX_W-1:0] < win.idx))
        begin
          tie_lost = 1'b1;
        end
      end
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  a_flag_set_wins: assert property (ce && (|set_vec) |=> ((st_q.flag & $past(set_vec)) == $past(set_vec)))
    else $error("request flag not set");
  a_flag_holds: assert property (ce |=> (((st_q.flag ^ $past(st_q.flag)) & ~$past(set_vec | irq_flag_clr)) == '0))
    else $error("request flag changed without cause");
  a_disabled_quiet: assert property (ce && (eligible == '0) |=> !irq_req_q)
    else $error("request raised with no enabled flagged source");
  a_vector_latch: assert property (ce && take |=> vector_number_q == pvc_pkg::vector_of($past(win.idx)))
    else $error("vector number not latched");
  a_level_match: assert property (ce && take |=> new_cpu_level_q == {1'b0, $past(win.pri)})
    else $error("new level differs from winner priority");
  a_zero_never: assert property (win.valid |-> win.pri != pvc_pkg::PRI_NONE)
    else $error("priority zero source presented");
  a_above_level: assert property (ce ##1 irq_req_q |-> new_cpu_level_q > $past(cur_lvl))
    else $error("request not above cpu level");
  a_ext_zero_vec: assert property (ce && take && win.idx == '0 |=> vector_number_q == pvc_pkg::VEC_BASE)
    else $error("external zero vector wrong");
  a_cpu_write: assert property (ce && cpu_level_wr && !irq_ack |=> cpu_priority_level_q[pvc_pkg::PRI_W-1:0] == $past(cpu_level_wdata))
    else $error("cpu level write lost");
  a_msb_readonly: assert property (ce && !trap_ack && !trap_return |=> $stable(st_q.lvl_msb))
    else $error("level msb moved without trap");
  a_nest_disable: assert property (ce && irq_ack && nesting_disable |=> st_q.cpu_lvl == pvc_pkg::CPU_LVL_MAX)
    else $error("nesting disable ignored");
  a_trap_request: assert property (ce && soft_hard_trap |=> trap_req_q)
    else $error("soft hard trap not raised");
  a_dbe_sticky: assert property (ce && ecc_dbe_event |=> double_bit_error_trap_q)
    else $error("double-bit error flag lost");

  // ****************************************************************
  // flags and arbitration
  // ****************************************************************
  a_flag_frozen: assert property (!ce |=> $stable(st_q))
    else $error("state moved while frozen");
  a_flag_clear: assert property (ce && irq_flag_clr[5] && !set_vec[5] |=> !irq_flag_regs_q[5])
    else $error("request flag not cleared");
  a_ext_lands: assert property (ce && ext_pulse[0] |=> irq_flag_regs_q[0])
    else $error("external zero flag not on bit 0");
  a_winner_max: assert property (win.valid |-> !outranked)
    else $error("winner outranked by eligible source");
  a_tie_lower: assert property (win.valid |-> !tie_lost)
    else $error("tie not given to lower vector");
  a_winner_found: assert property (any_ranked |-> win.valid)
    else $error("ranked eligible source ignored");
  a_winner_real: assert property (win.valid |-> eligible[win.idx])
    else $error("winner not eligible");
  a_enable_gate: assert property (take |-> irq_enable_regs[win.idx] && st_q.flag[win.idx])
    else $error("disabled or unflagged source taken");
  a_pri_field: assert property (take |-> win.pri == pvc_pkg::pri_of(irq_priority_regs, win.idx))
    else $error("winner priority not from its field");
  a_global_gate: assert property (ce && !global_irq_enable |=> !irq_req_q)
    else $error("request with global enable off");
  a_level_blocks: assert property (ce && win.valid && !take |=> !irq_req_q)
    else $error("request at or below cpu level");
  a_msb_masks: assert property (ce && st_q.lvl_msb |=> !irq_req_q)
    else $error("user request while level msb set");

  // ****************************************************************
  // latched status and cpu level
  // ****************************************************************
  a_req_nonzero: assert property (irq_req_q |-> new_cpu_level_q != pvc_pkg::LVL_RST)
    else $error("request with zero new level");
  a_vec_hold: assert property (ce && !take |=> $stable(vector_number_q) && $stable(new_cpu_level_q))
    else $error("latched status moved without a winner");
  a_ack_level: assert property (ce && irq_ack && !nesting_disable |=> {1'b0, st_q.cpu_lvl} == $past(new_cpu_level_q))
    else $error("ack did not load new level");
  a_level_hold: assert property (ce && !irq_ack && !cpu_level_wr |=> $stable(st_q.cpu_lvl))
    else $error("cpu level moved without cause");
  a_msb_set: assert property (ce && trap_ack |=> cpu_priority_level_q[pvc_pkg::LVL_W-1])
    else $error("trap entry did not set level msb");
  a_msb_clear: assert property (ce && !trap_ack && trap_return |=> !cpu_priority_level_q[pvc_pkg::LVL_W-1])
    else $error("trap return did not clear level msb");

  // ****************************************************************
  // traps and control
  // ****************************************************************
  a_trap_set: assert property (ce && trap_event[0] && trap_event_en[0] |=> trap_status_q[0])
    else $error("enabled trap event not flagged");
  a_trap_clear: assert property (ce && trap_flag_clr[0] && !(trap_event[0] && trap_event_en[0]) |=> !trap_status_q[0])
    else $error("trap flag not cleared");
  a_trap_masked: assert property (ce && trap_event[1] && !trap_event_en[1] && !trap_status_q[1] |=> !trap_status_q[1])
    else $error("disabled trap event flagged");
  a_dbe_clear: assert property (ce && double_bit_error_clr && !ecc_dbe_event |=> !double_bit_error_trap_q)
    else $error("double-bit error flag not cleared");
  a_trap_from_flag: assert property (ce && double_bit_error_trap_q |=> trap_req_q)
    else $error("double-bit error raised no trap");
  a_trap_idle: assert property (ce && !soft_hard_trap && !double_bit_error_trap_q && trap_status_q == '0 |=> !trap_req_q)
    else $error("trap request with no cause");
  a_alt_follow: assert property (ce |=> alt_table_sel_q == $past(alternate_vector_table))
    else $error("alternate table select not followed");

  c_take: cover property (ce && take);
  c_masked: cover property (ce && win.valid && !take);
  c_nested_ack: cover property (ce && irq_ack && nesting_disable);
  c_trap_cycle: cover property (ce && trap_ack ##[1:20] ce && trap_return);
  c_ext_falling: cover property (ce && ext_pulse[1] && ext_edge_falling[1]);

endmodule

// ---- design/pvc_edge_detect.sv ----
// polarity-selectable edge detector for the external request inputs
`timescale 1ns/1ps
module pvc_edge_detect
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  // pins and polarity, 1 selects the falling edge
  input wire logic [pvc_pkg::NEXT-1:0] ext_in,
  input wire logic [pvc_pkg::NEXT-1:0] edge_falling,
  // one-cycle pulse per detected edge
  output logic [pvc_pkg::NEXT-1:0] edge_pulse
);

  pvc_pkg::pvc_edge_state_t st_q;
  pvc_pkg::pvc_edge_state_t st_d;

  always_comb
  begin
    st_d = st_q;
    if (ce)
    begin
      st_d.prev = ext_in;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // frozen while ce is low, so no edge is reported twice
  assign edge_pulse = {pvc_pkg::NEXT{ce}} &
                      ((edge_falling & st_q.prev & ~ext_in) | (~edge_falling & ~st_q.prev & ext_in));

endmodule

// ---- design/pvc_pkg.sv ----
// shared constants, types and helpers for the prioritized vector controller
package pvc_pkg;

  // ****************************************************************
  // sizes
  // ****************************************************************
  localparam int NSRC = 16;
  localparam int NEXT = 2;
  localparam int IDX_W = 4;
  localparam int PRI_W = 3;
  localparam int LVL_W = 4;
  localparam int VEC_W = 8;
  localparam int NTRAP = 4;
  // each source owns a 4-bit slot, priority in its low three bits
  localparam int PRI_SLOT = 4;

  // ****************************************************************
  // values
  // ****************************************************************
  localparam logic [VEC_W-1:0] VEC_BASE = 8'h08;
  localparam logic [PRI_W-1:0] PRI_NONE = 3'h0;
  localparam logic [PRI_W-1:0] CPU_LVL_MAX = 3'h7;
  localparam logic [PRI_W-1:0] CPU_LVL_RST = 3'h0;
  localparam logic [VEC_W-1:0] VEC_RST = 8'h00;
  localparam logic [LVL_W-1:0] LVL_RST = 4'h0;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef struct packed {
    logic [NSRC-1:0] flag;
    logic [NTRAP-1:0] trap_flag;
    logic dbe_flag;
    logic [PRI_W-1:0] cpu_lvl;
    logic lvl_msb;
    logic [VEC_W-1:0] vec;
    logic [LVL_W-1:0] new_lvl;
    logic irq_req;
    logic trap_req;
    logic alt_tbl;
  } pvc_state_t;

  typedef struct packed {
    logic [NEXT-1:0] prev;
  } pvc_edge_state_t;

  typedef struct packed {
    logic valid;
    logic [IDX_W-1:0] idx;
    logic [PRI_W-1:0] pri;
  } pvc_win_t;

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [VEC_W-1:0] vector_of(input logic [IDX_W-1:0] idx);
    vector_of = VEC_BASE + {{(VEC_W-IDX_W){1'b0}}, idx};
  endfunction

  function automatic logic above_level(input logic [PRI_W-1:0] pri, input logic [LVL_W-1:0] lvl);
    above_level = ({1'b0, pri} > lvl);
  endfunction

  function automatic logic [PRI_W-1:0] pri_of(input logic [NSRC*PRI_SLOT-1:0] flat, input int i);
    pri_of = flat[i*PRI_SLOT +: PRI_W];
  endfunction

endpackage

// ---- dv/pvc_cpu_model.sv ----
// cpu-side partner model that acknowledges interrupt requests
`timescale 1ns/1ps
module pvc_cpu_model
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // bench controls
  input wire logic accept_en,
  input wire logic slow,
  // request and acknowledge
  input wire logic irq_req_q,
  output logic irq_ack
);
  logic [1:0] wait_q;
  // slow mode waits three cycles; one-cycle ack then drop, since the request lags the level by a cycle
  always_ff @(posedge clk)
  begin
    if (sys_rst || !accept_en || !irq_req_q || irq_ack)
    begin
      wait_q <= 2'h0;
      irq_ack <= 1'b0;
    end
    else if (!slow || wait_q == 2'h3)
      irq_ack <= 1'b1;
    else
      wait_q <= wait_q + 2'h1;
  end
endmodule

// ---- dv/tb_top.sv ----
// self-checking bench for the prioritized vector controller
`timescale 1ns/1ps
module tb_top;
  logic clk, sys_rst, ce, nesting_disable, global_irq_enable, alternate_vector_table, soft_hard_trap;
  logic ecc_dbe_event, double_bit_error_clr, cpu_level_wr, irq_ack, trap_ack, trap_return, accept_en, slow;
  logic [1:0] ext_irq_in, ext_edge_falling;
  logic [15:2] periph_req;
  logic [15:0] irq_flag_clr, irq_enable_regs, irq_flag_regs_q;
  logic [63:0] irq_priority_regs;
  logic [3:0] trap_event, trap_event_en, trap_flag_clr, trap_status_q, cpu_priority_level_q, new_cpu_level_q;
  logic [2:0] cpu_level_wdata;
  logic [7:0] vector_number_q;
  logic double_bit_error_trap_q, irq_req_q, trap_req_q, alt_table_sel_q;
  int n_mismatch, checks_done;

  pvc_controller dut (.clk, .sys_rst, .ce, .ext_irq_in, .periph_req, .irq_flag_clr, .irq_enable_regs,
    .irq_priority_regs, .nesting_disable, .trap_event, .trap_event_en, .trap_flag_clr, .global_irq_enable,
    .ext_edge_falling, .alternate_vector_table, .soft_hard_trap, .ecc_dbe_event, .double_bit_error_clr,
    .cpu_level_wr, .cpu_level_wdata, .irq_ack, .trap_ack, .trap_return, .irq_flag_regs_q, .trap_status_q,
    .double_bit_error_trap_q, .cpu_priority_level_q, .vector_number_q, .new_cpu_level_q, .irq_req_q,
    .trap_req_q, .alt_table_sel_q);
  pvc_cpu_model cpu (.clk, .sys_rst, .accept_en, .slow, .irq_req_q, .irq_ack);

  // ****************************************************************
  // helpers
  // ****************************************************************
  task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic set_lvl(input logic [2:0] v);
    @(posedge clk) cpu_level_wr <= 1'b1;
    cpu_level_wdata <= v;
    @(posedge clk) cpu_level_wr <= 1'b0;
    step(2);
  endtask
  task automatic close_out();
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ****************************************************************
  // clock, reset and watchdog
  // ****************************************************************
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial
  begin
    repeat (3000) @(posedge clk);
    n_mismatch++;
    close_out();
  end

  // ****************************************************************
  // tests
  // ****************************************************************
  initial
  begin
    {nesting_disable, alternate_vector_table, soft_hard_trap, ecc_dbe_event, double_bit_error_clr} = '0;
    {cpu_level_wr, trap_ack, trap_return, accept_en, slow, ext_irq_in, ext_edge_falling} = '0;
    {periph_req, irq_flag_clr, irq_enable_regs, irq_priority_regs, cpu_level_wdata} = '0;
    {trap_event, trap_event_en, trap_flag_clr} = '0;
    sys_rst = 1'b1;
    ce = 1'b1;
    global_irq_enable = 1'b1;
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    step(1);
    cmp("flags", 16'h0000, irq_flag_regs_q);
    cmp("vector", 16'h0000, vector_number_q);
    @(posedge clk) periph_req[5] <= 1'b1;
    @(posedge clk) periph_req[5] <= 1'b0;
    step(3);
    cmp("flag held", 16'h0020, irq_flag_regs_q);
    @(posedge clk) irq_priority_regs[22:20] <= 3'h3;
    step(2);
    cmp("req disabled", 16'h0000, irq_req_q);
    @(posedge clk) irq_enable_regs[5] <= 1'b1;
    step(2);
    cmp("req", 16'h0001, irq_req_q);
    cmp("vector", 16'h000d, vector_number_q);
    cmp("new level", 16'h0003, new_cpu_level_q);
    @(posedge clk) global_irq_enable <= 1'b0;
    step(2);
    cmp("req gated", 16'h0000, irq_req_q);
    @(posedge clk) global_irq_enable <= 1'b1;
    irq_priority_regs[22:20] <= 3'h0;
    step(2);
    cmp("req pri zero", 16'h0000, irq_req_q);
    for (int p = 1; p < 8; p++)
    begin
      @(posedge clk) irq_priority_regs[22:20] <= p[2:0];
      step(2);
      cmp("new level", 16'(p), new_cpu_level_q);
    end
    @(posedge clk) periph_req[3] <= 1'b1;
    irq_enable_regs[3] <= 1'b1;
    irq_priority_regs[14:12] <= 3'h4;
    irq_priority_regs[22:20] <= 3'h4;
    @(posedge clk) periph_req[3] <= 1'b0;
    step(2);
    cmp("tie vector", 16'h000b, vector_number_q);
    @(posedge clk) irq_priority_regs[22:20] <= 3'h6;
    step(2);
    cmp("high vector", 16'h000d, vector_number_q);
    set_lvl(3'h6);
    cmp("cpu level", 16'h0006, cpu_priority_level_q);
    cmp("req at level", 16'h0000, irq_req_q);
    set_lvl(3'h5);
    cmp("req above", 16'h0001, irq_req_q);
    set_lvl(3'h0);
    @(posedge clk) accept_en <= 1'b1;
    slow <= 1'b1;
    step(10);
    cmp("acked level", 16'h0006, cpu_priority_level_q);
    cmp("req after ack", 16'h0000, irq_req_q);
    @(posedge clk) accept_en <= 1'b0;
    set_lvl(3'h0);
    @(posedge clk) nesting_disable <= 1'b1;
    accept_en <= 1'b1;
    slow <= 1'b0;
    step(6);
    cmp("nest off level", 16'h0007, cpu_priority_level_q);
    @(posedge clk) accept_en <= 1'b0;
    nesting_disable <= 1'b0;
    irq_flag_clr <= 16'h0028;
    @(posedge clk) irq_flag_clr <= 16'h0000;
    step(1);
    cmp("flags cleared", 16'h0000, irq_flag_regs_q);
    @(posedge clk) periph_req[4] <= 1'b1;
    irq_flag_clr <= 16'h0010;
    @(posedge clk) periph_req[4] <= 1'b0;
    irq_flag_clr <= 16'h0000;
    step(1);
    cmp("set beats clear", 16'h0010, irq_flag_regs_q);
    @(posedge clk) irq_flag_clr <= 16'h0010;
    @(posedge clk) irq_flag_clr <= 16'h0000;
    set_lvl(3'h0);
    @(posedge clk) ext_irq_in[0] <= 1'b1;
    irq_enable_regs[0] <= 1'b1;
    irq_priority_regs[2:0] <= 3'h2;
    ext_edge_falling[1] <= 1'b1;
    ext_irq_in[1] <= 1'b1;
    step(4);
    cmp("ext flags", 16'h0001, irq_flag_regs_q);
    cmp("ext vector", 16'h0008, vector_number_q);
    @(posedge clk) ext_irq_in[1] <= 1'b0;
    step(3);
    cmp("falling flag", 16'h0003, irq_flag_regs_q);
    @(posedge clk) trap_ack <= 1'b1;
    @(posedge clk) trap_ack <= 1'b0;
    step(1);
    cmp("level msb", 16'h0008, cpu_priority_level_q);
    @(posedge clk) trap_return <= 1'b1;
    @(posedge clk) trap_return <= 1'b0;
    step(1);
    cmp("level msb off", 16'h0000, cpu_priority_level_q);
    @(posedge clk) trap_event_en <= 4'h5;
    trap_event <= 4'h3;
    @(posedge clk) trap_event <= 4'h0;
    step(2);
    cmp("trap status", 16'h0001, trap_status_q);
    cmp("trap req", 16'h0001, trap_req_q);
    @(posedge clk) trap_flag_clr <= 4'h1;
    ecc_dbe_event <= 1'b1;
    @(posedge clk) trap_flag_clr <= 4'h0;
    ecc_dbe_event <= 1'b0;
    step(1);
    cmp("trap cleared", 16'h0000, trap_status_q);
    cmp("dbe flag", 16'h0001, double_bit_error_trap_q);
    @(posedge clk) double_bit_error_clr <= 1'b1;
    @(posedge clk) double_bit_error_clr <= 1'b0;
    step(2);
    cmp("trap req idle", 16'h0000, trap_req_q);
    @(posedge clk) soft_hard_trap <= 1'b1;
    alternate_vector_table <= 1'b1;
    step(2);
    cmp("soft trap", 16'h0001, trap_req_q);
    cmp("alt table", 16'h0001, alt_table_sel_q);
    @(posedge clk) ce <= 1'b0;
    periph_req[7] <= 1'b1;
    step(2);
    cmp("frozen flags", 16'h0003, irq_flag_regs_q);
    @(posedge clk) ce <= 1'b1;
    periph_req[7] <= 1'b0;
    step(2);
    cmp("thawed flags", 16'h0003, irq_flag_regs_q);
    close_out();
  end
endmodule
